// ==== bxr_pkg.sv ====
// constants, field layouts and carrier types of the bridge extension
// configuration register bank; shared by every design file.
package bxr_pkg;

	// ----------------------------------------------------------------
	// configuration offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_EXT_LO   = 8'h40;
	localparam logic [7:0] OFS_SVID     = 8'h40;
	localparam logic [7:0] OFS_SID      = 8'h42;
	localparam logic [7:0] OFS_W0_BASE  = 8'h44;
	localparam logic [7:0] OFS_W0_LIM   = 8'h48;
	localparam logic [7:0] OFS_W1_BASE  = 8'h4c;
	localparam logic [7:0] OFS_W1_LIM   = 8'h50;
	localparam logic [7:0] OFS_SERR_CTL = 8'h60;
	localparam logic [7:0] OFS_SERR_STS = 8'h61;
	localparam logic [7:0] OFS_WIN_EN   = 8'h64;
	localparam logic [7:0] OFS_WIN_MAP  = 8'h65;

	// ----------------------------------------------------------------
	// reset values and field layouts
	// ----------------------------------------------------------------
	localparam logic [15:0] IDENT_RST    = 16'h0000;
	localparam logic [31:0] WIN_RST      = 32'h0000_0000;
	localparam logic [1:0]  WIN_FLAG_RST = 2'h0;
	localparam logic [7:0]  SERR_CTL_RST = 8'h0e;
	localparam logic [7:0]  SERR_STS_RST = 8'h00;
	localparam logic [7:0]  SERR_CTL_MSK = 8'h3f;
	localparam logic [1:0]  BASE_RO_MSK  = 2'h3;
	localparam int          TYPE_IO_BIT  = 1;
	localparam int          TYPE_PF_BIT  = 0;
	localparam logic [11:0] MEM_GRAN_ONE = 12'hfff;
	localparam logic [1:0]  IO_GRAN_ONE  = 2'h3;
	localparam int          SERR_DPE_BIT = 5;
	localparam int          SERR_DTO_BIT = 4;
	localparam int          SERR_PMA_BIT = 3;
	localparam int          SERR_PTA_BIT = 2;
	localparam int          SERR_PPE_BIT = 1;
	localparam int          SERR_ARB_BIT = 0;
	localparam int          NUM_WIN      = 2;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} bxr_cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} bxr_cfg_rsp_t;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] limit;
		logic        en;
		logic        map;
	} bxr_win_cfg_t;

	typedef struct packed {
		logic        valid;
		logic        is_io;
		logic [31:0] addr;
	} bxr_dec_req_t;

	typedef struct packed {
		logic [1:0] prim_hit;
		logic [1:0] sec_hit;
		logic [1:0] prefetch;
	} bxr_dec_rsp_t;

	// byte-lane merge of a config write into a stored dword
	function automatic logic [31:0] bxr_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// same dword as a printed byte offset
	function automatic logic bxr_dw(input logic [7:0] a,
		input logic [7:0] ofs);
		return a[7:2] == ofs[7:2];
	endfunction

endpackage

// ==== bxr_win.sv ====
// one extension window: effective bounds and registered hit decode.
// assumes the request is stable for the cycle it is sampled in.
`timescale 1ns/100ps
module bxr_win (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  reset,
	// window setup
	input  wire bxr_pkg::bxr_win_cfg_t cfg,
	// address to decode
	input  wire bxr_pkg::bxr_dec_req_t req,
	// registered hits
	output logic                       prim_hit,
	output logic                       sec_hit,
	output logic                       prefetch
);

	typedef struct packed {
		logic prim;
		logic sec;
		logic pf;
	} bxr_win_st_t;

	bxr_win_st_t st_q;
	bxr_win_st_t st_d;
	logic        io_win;
	logic [31:0] eff_base;
	logic [31:0] eff_lim;
	logic        hit;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	always_comb begin
		io_win = cfg.limit[bxr_pkg::TYPE_IO_BIT];
		if (io_win) begin
			eff_base = {cfg.base[31:2], 2'h0};
			eff_lim  = {cfg.limit[31:2], bxr_pkg::IO_GRAN_ONE};
		end else begin
			eff_base = {cfg.base[31:12], 12'h000};
			eff_lim  = {cfg.limit[31:12], bxr_pkg::MEM_GRAN_ONE};
		end
		// memory windows claim only memory cycles and vice versa
		hit = req.valid && cfg.en && (req.is_io == io_win)
			&& (req.addr >= eff_base) && (req.addr <= eff_lim);
		st_d.prim = hit && !cfg.map;
		st_d.sec  = hit && cfg.map;
		st_d.pf   = hit && !io_win && cfg.limit[bxr_pkg::TYPE_PF_BIT];
		if (reset) begin
			st_d = '0;
		end
	end

	always_ff @(posedge mclk) begin
		st_q <= st_d;
	end

	assign prim_hit = st_q.prim;
	assign sec_hit  = st_q.sec;
	assign prefetch = st_q.pf;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_hit_in_range: assert property (@(posedge mclk) disable iff (reset)
		(prim_hit || sec_hit) |-> ($past(req.addr) >= $past(eff_base))
		&& ($past(req.addr) <= $past(eff_lim)))
		else $error("window hit outside its bounds");

	a_enable_gates: assert property (@(posedge mclk) disable iff (reset)
		!cfg.en |=> !prim_hit && !sec_hit)
		else $error("disabled window produced a hit");

	a_map_splits: assert property (@(posedge mclk) disable iff (reset)
		$past(cfg.map) |-> !prim_hit)
		else $error("excluded window hit on primary");

	a_mem_gran: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && !req.is_io && cfg.en && !io_win
		&& req.addr[31:12] == cfg.limit[31:12]
		&& cfg.base[31:12] <= cfg.limit[31:12]) |=> (prim_hit || sec_hit))
		else $error("memory limit page not fully decoded");

endmodule

// ==== bxr_serr.sv ====
// system-error control and sticky status byte.
// assumes each event input is a one-cycle pulse from the forwarding logic.
`timescale 1ns/100ps
module bxr_serr (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	// register writes
	input  wire logic       ctl_we,
	input  wire logic [7:0] ctl_wdata,
	input  wire logic       sts_we,
	input  wire logic [7:0] sts_wdata,
	// error events
	input  wire logic [5:0] evt,
	// state
	output logic [7:0]      ctl,
	output logic [7:0]      sts,
	output logic            serr_req
);

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] sts;
	} bxr_serr_st_t;

	bxr_serr_st_t st_q;
	bxr_serr_st_t st_d;
	logic [7:0]   set;

	// ----------------------------------------------------------------
	// control and status update
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// each enable picks its own event source
		set = {2'h0, evt} & st_q.ctl & bxr_pkg::SERR_CTL_MSK;
		if (ctl_we) begin
			st_d.ctl = ctl_wdata & bxr_pkg::SERR_CTL_MSK;
		end
		// write-one clears; a new event in the same cycle still sets
		if (sts_we) begin
			st_d.sts = st_q.sts & ~sts_wdata;
		end
		st_d.sts = st_d.sts | set;
		if (reset) begin
			st_d.ctl = bxr_pkg::SERR_CTL_RST;
			st_d.sts = bxr_pkg::SERR_STS_RST;
		end
	end

	always_ff @(posedge mclk) begin
		st_q <= st_d;
	end

	assign ctl      = st_q.ctl;
	assign sts      = st_q.sts;
	assign serr_req = |st_q.sts;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_ctl_reset_val: assert property (@(posedge mclk) disable iff (reset)
		$past(reset) |-> ctl == 8'h0e)
		else $error("error control reset value wrong");

	a_sts_mirrors: assert property (@(posedge mclk) disable iff (reset)
		(evt[bxr_pkg::SERR_PMA_BIT] && ctl[bxr_pkg::SERR_PMA_BIT])
		|=> sts[bxr_pkg::SERR_PMA_BIT] && serr_req)
		else $error("enabled event did not set status");

	a_masked_quiet: assert property (@(posedge mclk) disable iff (reset)
		(!ctl[bxr_pkg::SERR_ARB_BIT] && !sts[bxr_pkg::SERR_ARB_BIT])
		|=> !sts[bxr_pkg::SERR_ARB_BIT])
		else $error("disabled event set status");

endmodule

// ==== bxr_regs.sv ====
// bridge extension configuration register bank top level.
// assumes config cycles arrive as one-cycle strobes already decoded to
// this function; address is the byte offset, lanes qualified by be.
`timescale 1ns/100ps
module bxr_regs (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  reset,
	// configuration access
	input  wire bxr_pkg::bxr_cfg_req_t cfg_req,
	output bxr_pkg::bxr_cfg_rsp_t      cfg_rsp,
	// serial eeprom loader
	input  wire logic                  ee_load,
	input  wire logic [15:0]           ee_svid,
	input  wire logic [15:0]           ee_sid,
	// error events and report
	input  wire logic [5:0]            serr_evt,
	output logic                       serr_req,
	// window decode
	input  wire bxr_pkg::bxr_dec_req_t dec_req,
	output bxr_pkg::bxr_dec_rsp_t      dec_rsp
);

	typedef struct packed {
		logic [15:0]      svid;
		logic [15:0]      sid;
		logic [1:0][31:0] base;
		logic [1:0][31:0] lim;
		logic [1:0]       en;
		logic [1:0]       map;
		logic             ack;
		logic [31:0]      rdata;
	} bxr_regs_st_t;

	bxr_regs_st_t          st_q;
	bxr_regs_st_t          st_d;
	logic                  in_ext;
	logic                  wr_ok;
	logic                  rd_ok;
	logic [31:0]           mrg;
	logic [31:0]           rd_word;
	logic [7:0]            serr_ctl;
	logic [7:0]            serr_sts;
	logic                  serr_ctl_we;
	logic                  serr_sts_we;
	bxr_pkg::bxr_win_cfg_t win_cfg [bxr_pkg::NUM_WIN];

	// ----------------------------------------------------------------
	// access qualification
	// ----------------------------------------------------------------
	// only the extension area belongs here; the standard header is
	// answered elsewhere, so no ack is raised below it
	assign in_ext = cfg_req.addr >= bxr_pkg::OFS_EXT_LO;
	assign wr_ok  = cfg_req.wr && in_ext;
	assign rd_ok  = cfg_req.rd && in_ext;

	assign serr_ctl_we = wr_ok && cfg_req.be[0]
		&& bxr_pkg::bxr_dw(cfg_req.addr, bxr_pkg::OFS_SERR_CTL);
	assign serr_sts_we = wr_ok && cfg_req.be[1]
		&& bxr_pkg::bxr_dw(cfg_req.addr, bxr_pkg::OFS_SERR_STS);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		case (cfg_req.addr[7:2])
			bxr_pkg::OFS_SVID[7:2]: begin
				rd_word = {st_q.sid, st_q.svid};
			end
			bxr_pkg::OFS_W0_BASE[7:2]: begin
				rd_word = {st_q.base[0][31:2], 2'h0};
			end
			bxr_pkg::OFS_W0_LIM[7:2]: begin
				rd_word = st_q.lim[0];
			end
			bxr_pkg::OFS_W1_BASE[7:2]: begin
				rd_word = {st_q.base[1][31:2], 2'h0};
			end
			bxr_pkg::OFS_W1_LIM[7:2]: begin
				rd_word = st_q.lim[1];
			end
			bxr_pkg::OFS_SERR_CTL[7:2]: begin
				rd_word = {16'h0000, serr_sts,
					serr_ctl & bxr_pkg::SERR_CTL_MSK};
			end
			bxr_pkg::OFS_WIN_EN[7:2]: begin
				rd_word = {16'h0000, 6'h00, st_q.map, 6'h00, st_q.en};
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// register update
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		mrg  = 32'h0000_0000;
		st_d.ack = cfg_req.wr && in_ext || rd_ok;
		if (rd_ok) begin
			st_d.rdata = rd_word;
		end
		if (wr_ok) begin
			case (cfg_req.addr[7:2])
				bxr_pkg::OFS_SVID[7:2]: begin
					mrg = bxr_pkg::bxr_merge({st_q.sid, st_q.svid},
						cfg_req.wdata, cfg_req.be);
					st_d.svid = mrg[15:0];
					st_d.sid  = mrg[31:16];
				end
				bxr_pkg::OFS_W0_BASE[7:2]: begin
					mrg = bxr_pkg::bxr_merge(st_q.base[0],
						cfg_req.wdata, cfg_req.be);
					st_d.base[0] = mrg & ~{30'h0, bxr_pkg::BASE_RO_MSK};
				end
				bxr_pkg::OFS_W0_LIM[7:2]: begin
					st_d.lim[0] = bxr_pkg::bxr_merge(st_q.lim[0],
						cfg_req.wdata, cfg_req.be);
				end
				bxr_pkg::OFS_W1_BASE[7:2]: begin
					mrg = bxr_pkg::bxr_merge(st_q.base[1],
						cfg_req.wdata, cfg_req.be);
					st_d.base[1] = mrg & ~{30'h0, bxr_pkg::BASE_RO_MSK};
				end
				bxr_pkg::OFS_W1_LIM[7:2]: begin
					st_d.lim[1] = bxr_pkg::bxr_merge(st_q.lim[1],
						cfg_req.wdata, cfg_req.be);
				end
				bxr_pkg::OFS_WIN_EN[7:2]: begin
					if (cfg_req.be[0]) begin
						st_d.en = cfg_req.wdata[1:0];
					end
					if (cfg_req.be[1]) begin
						st_d.map = cfg_req.wdata[9:8];
					end
				end
				default: begin
					mrg = 32'h0000_0000;
				end
			endcase
		end
		// the loader outranks a racing driver write; software is
		// expected to leave loaded idents alone afterwards
		if (ee_load) begin
			st_d.svid = ee_svid;
			st_d.sid  = ee_sid;
		end
		if (reset) begin
			st_d.svid  = bxr_pkg::IDENT_RST;
			st_d.sid   = bxr_pkg::IDENT_RST;
			st_d.base  = {bxr_pkg::WIN_RST, bxr_pkg::WIN_RST};
			st_d.lim   = {bxr_pkg::WIN_RST, bxr_pkg::WIN_RST};
			st_d.en    = bxr_pkg::WIN_FLAG_RST;
			st_d.map   = bxr_pkg::WIN_FLAG_RST;
			st_d.ack   = 1'b0;
			st_d.rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk) begin
		st_q <= st_d;
	end

	assign cfg_rsp.ack   = st_q.ack;
	assign cfg_rsp.rdata = st_q.rdata;

	// ----------------------------------------------------------------
	// error reporting
	// ----------------------------------------------------------------
	bxr_serr u_serr (
		.mclk      (mclk),
		.reset     (reset),
		.ctl_we    (serr_ctl_we),
		.ctl_wdata (cfg_req.wdata[7:0]),
		.sts_we    (serr_sts_we),
		.sts_wdata (cfg_req.wdata[15:8]),
		.evt       (serr_evt),
		.ctl       (serr_ctl),
		.sts       (serr_sts),
		.serr_req  (serr_req)
	);

	// ----------------------------------------------------------------
	// extension windows
	// ----------------------------------------------------------------
	for (genvar w = 0; w < bxr_pkg::NUM_WIN; w++) begin : g_win
		assign win_cfg[w].base  = st_q.base[w];
		assign win_cfg[w].limit = st_q.lim[w];
		assign win_cfg[w].en    = st_q.en[w];
		assign win_cfg[w].map   = st_q.map[w];

		bxr_win u_win (
			.mclk     (mclk),
			.reset    (reset),
			.cfg      (win_cfg[w]),
			.req      (dec_req),
			.prim_hit (dec_rsp.prim_hit[w]),
			.sec_hit  (dec_rsp.sec_hit[w]),
			.prefetch (dec_rsp.prefetch[w])
		);
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_ext_read;
		cfg_req.rd && cfg_req.addr >= 8'h40;
	endsequence

	sequence s_base0_read;
		cfg_req.rd && cfg_req.addr[7:2] == 6'h11;
	endsequence

	sequence s_ctl_read;
		cfg_req.rd && cfg_req.addr[7:2] == 6'h18;
	endsequence

	a_read_ack: assert property (@(posedge mclk) disable iff (reset)
		s_ext_read |=> cfg_rsp.ack ##1 !cfg_rsp.ack || $past(cfg_req.rd)
		|| $past(cfg_req.wr))
		else $error("extension read not acknowledged once");

	a_hdr_silent: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.addr < 8'h40) |=> !cfg_rsp.ack)
		else $error("header access acknowledged here");

	a_base_low0: assert property (@(posedge mclk) disable iff (reset)
		s_base0_read |=> cfg_rsp.rdata[1:0] == 2'h0)
		else $error("base low bits read nonzero");

	a_ctl_rsvd: assert property (@(posedge mclk) disable iff (reset)
		s_ctl_read |=> cfg_rsp.rdata[7:6] == 2'h0)
		else $error("error control reserved bits nonzero");

	a_svid_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h10 && cfg_req.be[0]
		&& !ee_load) |=> st_q.svid[7:0] == $past(cfg_req.wdata[7:0]))
		else $error("vendor ident write lost");

	a_ee_load: assert property (@(posedge mclk) disable iff (reset)
		ee_load |=> st_q.sid == $past(ee_sid) && st_q.svid == $past(ee_svid))
		else $error("eeprom load did not land");

	a_lim_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h14 && cfg_req.be == 4'hf)
		|=> st_q.lim[1] == $past(cfg_req.wdata))
		else $error("limit write lost");

	// ----------------------------------------------------------------
	// landing, refusal and reset checks
	// ----------------------------------------------------------------
	sequence s_ext_write;
		cfg_req.wr && cfg_req.addr >= bxr_pkg::OFS_EXT_LO;
	endsequence

	a_write_ack: assert property (@(posedge mclk) disable iff (reset)
		s_ext_write |=> cfg_rsp.ack)
		else $error("extension write not acknowledged");

	a_idle_quiet: assert property (@(posedge mclk) disable iff (reset)
		(!cfg_req.wr && !cfg_req.rd) |=> !cfg_rsp.ack)
		else $error("acknowledge without an access");

	a_rdata_holds: assert property (@(posedge mclk) disable iff (reset)
		!cfg_req.rd |=> $stable(cfg_rsp.rdata))
		else $error("read data moved without a read");

	a_unmapped_zero: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.rd && cfg_req.addr >= 8'h68)
		|=> cfg_rsp.rdata == 32'h0000_0000)
		else $error("unmapped dword read nonzero");

	a_pre_write_rd: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.rd && cfg_req.wr && cfg_req.addr[7:2] == 6'h12)
		|=> cfg_rsp.rdata == $past(st_q.lim[0]))
		else $error("combined access did not read old limit");

	a_sid_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h10 && cfg_req.be[2]
		&& !ee_load) |=> st_q.sid[7:0] == $past(cfg_req.wdata[23:16]))
		else $error("ident write lost");

	a_base0_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h11 && cfg_req.be == 4'hf)
		|=> st_q.base[0] == {$past(cfg_req.wdata[31:2]), 2'h0})
		else $error("window 0 base write lost");

	a_base1_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h13 && cfg_req.be == 4'hf)
		|=> st_q.base[1] == {$past(cfg_req.wdata[31:2]), 2'h0})
		else $error("window 1 base write lost");

	a_lim0_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h12 && cfg_req.be == 4'hf)
		|=> st_q.lim[0] == $past(cfg_req.wdata))
		else $error("window 0 limit write lost");

	a_en_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h19 && cfg_req.be[0])
		|=> st_q.en == $past(cfg_req.wdata[1:0]))
		else $error("window enable write lost");

	a_map_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h19 && cfg_req.be[1])
		|=> st_q.map == $past(cfg_req.wdata[9:8]))
		else $error("window map write lost");

	a_en_rsvd: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.rd && cfg_req.addr[7:2] == 6'h19)
		|=> cfg_rsp.rdata[7:2] == 6'h00 && cfg_rsp.rdata[31:10] == 22'h0)
		else $error("enable and map reserved bits nonzero");

	a_ctl_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h18 && cfg_req.be[0])
		|=> serr_ctl
		== ($past(cfg_req.wdata[7:0]) & bxr_pkg::SERR_CTL_MSK))
		else $error("error control write lost");

	a_sts_w1c: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr[7:2] == 6'h18 && cfg_req.be[1]
		&& serr_evt == 6'h00)
		|=> (serr_sts & $past(cfg_req.wdata[15:8])) == 8'h00)
		else $error("error status not cleared by write");

	a_hdr_no_write: assert property (@(posedge mclk) disable iff (reset)
		(cfg_req.wr && cfg_req.addr < 8'h40)
		|=> $stable(st_q.base) && $stable(st_q.lim) && $stable(st_q.en))
		else $error("header write changed a register");

	a_ee_wins: assert property (@(posedge mclk) disable iff (reset)
		(ee_load && cfg_req.wr && cfg_req.addr[7:2] == 6'h10)
		|=> st_q.svid == $past(ee_svid))
		else $error("eeprom load lost to a config write");

	a_id_reset: assert property (@(posedge mclk) disable iff (reset)
		$past(reset) |-> st_q.svid == bxr_pkg::IDENT_RST
		&& st_q.sid == bxr_pkg::IDENT_RST)
		else $error("idents not cleared by reset");

	a_win_reset: assert property (@(posedge mclk) disable iff (reset)
		$past(reset) |-> st_q.en == bxr_pkg::WIN_FLAG_RST
		&& st_q.map == bxr_pkg::WIN_FLAG_RST)
		else $error("window flags not cleared by reset");

	a_rsp_reset: assert property (@(posedge mclk) disable iff (reset)
		$past(reset) |-> !cfg_rsp.ack
		&& cfg_rsp.rdata == 32'h0000_0000)
		else $error("response not cleared by reset");

endmodule

// ==== bxr_host.sv ====
// behavioural host that issues configuration reads and writes.
// assumes the testbench calls access from one process at a time.
`timescale 1ns/100ps
module bxr_host (
	// clock
	input  wire logic                  mclk,
	// configuration bus
	output bxr_pkg::bxr_cfg_req_t      cfg_req,
	input  wire bxr_pkg::bxr_cfg_rsp_t cfg_rsp
);
	initial begin
		cfg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h3c, be: 4'h5,
			wdata: 32'h5a5a_5a5a};
	end

	// ------------------------------------------------------------
	// one access: strobe for one cycle, answer taken the next
	// ------------------------------------------------------------
	task automatic access(input logic w, input logic r,
		input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
		output logic ack, output logic [31:0] q);
		@(negedge mclk);
		cfg_req = '{wr: w, rd: r, addr: a, be: be, wdata: wd};
		@(negedge mclk);
		ack = cfg_rsp.ack;
		q = cfg_rsp.rdata;
		// released lines show the inverse so stale values never match
		cfg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~be, wdata: ~wd};
	endtask
endmodule

// ==== bxr_regs_tb.sv ====
// self-checking bench for the extension register bank.
// assumes bxr_host drives the configuration bus on falling edges.
`timescale 1ns/100ps
module bxr_regs_tb;
	typedef struct {
		logic [7:0]  a;
		logic [3:0]  be;
		logic [31:0] wd;
		logic [31:0] rst;
		logic [31:0] exp;
	} bxr_tb_row_t;
	typedef struct {
		logic [31:0] a;
		logic        io;
		logic [5:0]  exp;
	} bxr_tb_dec_t;

	logic                  mclk = 1'b0;
	logic                  reset = 1'b1;
	bxr_pkg::bxr_cfg_req_t cfg_req;
	bxr_pkg::bxr_cfg_rsp_t cfg_rsp;
	logic                  ee_load = 1'b0;
	logic [15:0]           ee_svid = 16'h0000;
	logic [15:0]           ee_sid = 16'h0000;
	logic [5:0]            serr_evt = 6'h00;
	logic                  serr_req;
	bxr_pkg::bxr_dec_req_t dec_req = '0;
	bxr_pkg::bxr_dec_rsp_t dec_rsp;
	int                    errors = 0;
	int                    checks = 0;
	logic [31:0]           q;
	logic                  ack;

	bxr_tb_row_t rows [8] = '{
		'{8'h40, 4'hf, 32'h1234_5678, 32'h0, 32'h1234_5678},
		'{8'h44, 4'hf, 32'hffff_ffff, 32'h0, 32'hffff_fffc},
		'{8'h48, 4'hf, 32'ha5a5_a5a5, 32'h0, 32'ha5a5_a5a5},
		'{8'h4c, 4'h3, 32'hffff_ffff, 32'h0, 32'h0000_fffc},
		'{8'h50, 4'hc, 32'h8765_4321, 32'h0, 32'h8765_0000},
		'{8'h60, 4'hf, 32'hffff_ffff, 32'he, 32'h0000_003f},
		'{8'h64, 4'hf, 32'hffff_ffff, 32'h0, 32'h0000_0303},
		'{8'h70, 4'hf, 32'hffff_ffff, 32'h0, 32'h0000_0000}
	};
	// window 0: prefetchable memory 0x12000..0x13fff, primary
	// window 1: io 0x100..0x10b, excluded from primary
	bxr_tb_dec_t drows [9] = '{
		'{32'h0001_1fff, 1'b0, 6'h00}, '{32'h0001_2000, 1'b0, 6'h11},
		'{32'h0001_3fff, 1'b0, 6'h11}, '{32'h0001_4000, 1'b0, 6'h00},
		'{32'h0001_2000, 1'b1, 6'h00}, '{32'h0000_0100, 1'b1, 6'h08},
		'{32'h0000_010b, 1'b1, 6'h08}, '{32'h0000_010c, 1'b1, 6'h00},
		'{32'h0000_00fc, 1'b1, 6'h00}
	};

	always #12.5 mclk = ~mclk;

	bxr_regs DUT (
		.mclk     (mclk),
		.reset    (reset),
		.cfg_req  (cfg_req),
		.cfg_rsp  (cfg_rsp),
		.ee_load  (ee_load),
		.ee_svid  (ee_svid),
		.ee_sid   (ee_sid),
		.serr_evt (serr_evt),
		.serr_req (serr_req),
		.dec_req  (dec_req),
		.dec_rsp  (dec_rsp)
	);

	bxr_host host (
		.mclk    (mclk),
		.cfg_req (cfg_req),
		.cfg_rsp (cfg_rsp)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic k;
		host.access(1'b0, 1'b1, a, 4'h0, 32'h0, k, d);
		check("read ack", {31'h0, k}, 32'h1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		logic        k;
		logic [31:0] x;
		host.access(1'b1, 1'b0, a, be, d, k, x);
		check("write ack", {31'h0, k}, 32'h1);
	endtask

	task automatic dec(input logic [31:0] a, input logic io,
		input logic [5:0] exp);
		@(negedge mclk);
		dec_req = '{valid: 1'b1, is_io: io, addr: a};
		@(negedge mclk);
		check("decode", {26'h0, dec_rsp}, {26'h0, exp});
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchdog: the tests need well under 1000 cycles
	// ------------------------------------------------------------
	initial begin
		#(25 * 4000);
		errors++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(negedge mclk);
		reset = 1'b0;
		foreach (rows[i]) begin
			rd(rows[i].a, q);
			check("reset value", q, rows[i].rst);
			wr(rows[i].a, rows[i].be, rows[i].wd);
			rd(rows[i].a, q);
			check("readback", q, rows[i].exp);
		end
		$display("register table done");

		host.access(1'b1, 1'b1, 8'h3c, 4'hf, 32'hffff_ffff, ack, q);
		check("low offset refused", {31'h0, ack}, 32'h0);
		host.access(1'b1, 1'b1, 8'h48, 4'hf, 32'h0000_0f0f, ack, q);
		check("read with write", q, 32'ha5a5_a5a5);
		rd(8'h48, q);
		check("write with read", q, 32'h0000_0f0f);
		$display("bus corners done");

		// loader and a config write land in the same cycle
		fork
			wr(8'h40, 4'hf, 32'hdead_beef);
			begin
				@(negedge mclk);
				ee_svid = 16'h1a2b;
				ee_sid = 16'h3c4d;
				ee_load = 1'b1;
				@(negedge mclk);
				ee_load = 1'b0;
			end
		join
		// host leaves the loaded idents alone from here on
		rd(8'h40, q);
		check("eeprom idents", q, 32'h3c4d_1a2b);
		$display("eeprom load done");

		wr(8'h60, 4'h1, 32'h0000_002a);
		@(negedge mclk);
		serr_evt = 6'h3f;
		@(negedge mclk);
		serr_evt = 6'h00;
		rd(8'h60, q);
		check("error status", q, 32'h0000_2a2a);
		check("error report", {31'h0, serr_req}, 32'h1);
		wr(8'h60, 4'h2, 32'h0000_2a00);
		rd(8'h60, q);
		check("status cleared", q, 32'h0000_002a);
		check("report dropped", {31'h0, serr_req}, 32'h0);
		$display("error reporting done");

		wr(8'h64, 4'h3, 32'h0000_0000);
		wr(8'h44, 4'hf, 32'h0001_2345);
		wr(8'h48, 4'hf, 32'h0001_3001);
		wr(8'h4c, 4'hf, 32'h0000_0100);
		wr(8'h50, 4'hf, 32'h0000_010a);
		dec(32'h0001_2000, 1'b0, 6'h00);
		wr(8'h64, 4'h3, 32'h0000_0203);
		foreach (drows[i]) begin
			dec(drows[i].a, drows[i].io, drows[i].exp);
		end
		$display("window decode done");

		@(negedge mclk);
		serr_evt = 6'h02;
		@(negedge mclk);
		serr_evt = 6'h00;
		check("report before reset", {31'h0, serr_req}, 32'h1);
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		reset = 1'b0;
		check("report after reset", {31'h0, serr_req}, 32'h0);
		rd(8'h60, q);
		check("control after reset", q, 32'h0000_000e);
		rd(8'h64, q);
		check("enables after reset", q, 32'h0000_0000);
		$display("second reset done");
		report_and_stop();
	end
endmodule
